// ---- hw/dio_defines.vh ----
// Purpose: shared constants of the instruction decode and sequencing block
// Assumes: included by bare name from hw/dio_decoder.v
// Notes:   definitions only
`ifndef DIO_DEFINES_VH
`define DIO_DEFINES_VH
// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define DIO_F_OPC   23:16
`define DIO_F_HI8   23:16
`define DIO_F_BIT_POSITION_FIELD  15:12
`define DIO_F_BASE  14:11
`define DIO_F_DST   10:7
`define DIO_F_SRC   3:0
`define DIO_F_LIT   13:4
`define DIO_B_LSIGN 13
`define DIO_B_BYTE  14
`define DIO_F_MAC   23:19
`define DIO_B_SQR   18
`define DIO_F_PAIR  17:15
`define DIO_F_SQP   16:15
`define DIO_B_ACC   14
`define DIO_F_XD    13:12
`define DIO_F_WX    11:8
`define DIO_F_YD    7:6
`define DIO_F_WY    5:2
`define DIO_F_AWB   1:0
`define DIO_F_ADRH  6:0
`define DIO_F_ADRL  15:0
// ----------------------------------------
// opcodes
// ----------------------------------------
`define DIO_OP_NOP   8'h00
`define DIO_OP_IND   8'h01
`define DIO_OP_CALL2 8'h02
`define DIO_OP_GOTO2 8'h04
`define DIO_OP_DO2   8'h08
`define DIO_OP_RET   8'h06
`define DIO_OP_RETI  8'h07
`define DIO_OP_TBL   8'hba
`define DIO_OP_MOVD  8'hbe
`define DIO_OP_SKIP  8'ha6
`define DIO_OP_LIT   8'hb0
`define DIO_BR_NIB   4'h3
`define DIO_MAC_TAG  5'h18
`define DIO_C_ALWAYS 4'h7
// ----------------------------------------
// timing, literals, registers
// ----------------------------------------
`define DIO_XTRA_ONE 2'h1
`define DIO_XTRA_TWO 2'h2
`define DIO_BYTE_MAX 10'h0ff
`define DIO_PAIR_MAX 3'h5
`define DIO_W0       4'h0
`define DIO_W4       4'h4
`define DIO_W8       4'h8
`define DIO_W9       4'h9
`define DIO_W10      4'ha
`define DIO_W11      4'hb
`define DIO_W12      4'hc
`define DIO_W13      4'hd
`define DIO_AWB_INC  4'h2
`define DIO_PF_W12   4'he
`define DIO_PF_NONE  4'hf
`define DIO_PF_HALF  4'h7
`define DIO_A_CTRL   8'h00
`define DIO_A_STAT   8'h04
`define DIO_A_ERR    8'h08
`define DIO_A_CNT    8'h0c
`define DIO_FL_C     0
`define DIO_FL_DC    1
`define DIO_FL_N     2
`define DIO_FL_OV    3
`define DIO_FL_Z     4
`define DIO_FL_OA    5
`define DIO_FL_OB    6
`define DIO_FL_SA    7
`define DIO_FL_SB    8
`define DIO_E_WORD2  0
`define DIO_E_LIT    1
`define DIO_E_ODD    2
`define DIO_E_PAIR   3
`define DIO_RST_CTRL 1'h1
`endif

// ---- hw/dio_decoder.v ----
// Purpose: instruction decode, operand field decode and cycle sequencing
// Assumes: one 200 MHz clock, synchronous active-high reset, classic wishbone
// Notes:   every output comes from a flip-flop
`timescale 1ns/10ps
`default_nettype none
`include "dio_defines.vh"

module dio_decoder (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	input  wire [3:0]  wb_sel_i,
	input  wire        wb_we_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        fetch_valid_i,
	input  wire [23:0] fetch_word_i,
	output reg         fetch_ready_o,
	input  wire        skip_true_i,
	input  wire [8:0]  flag_we_i,
	input  wire [8:0]  flag_val_i,
	output reg         exec_valid_o,
	output reg         exec_nop_o,
	output reg         exec_taken_o,
	output reg         exec_two_word_o,
	output reg  [7:0]  exec_opcode_o,
	output reg  [23:0] operand_ext_o,
	output reg  [22:0] program_addr_imm_o,
	output reg  [3:0]  base_reg_o,
	output reg  [3:0]  src_reg_o,
	output reg  [3:0]  dst_reg_o,
	output reg  [3:0]  implicit_work_register_o,
	output reg  [3:0]  bit_position_field_o,
	output reg  [9:0]  unsigned_imm_ten_o,
	output reg         byte_mode_o,
	output reg  [15:0] signed_imm_ten_o,
	output reg         acc_sel_o,
	output reg  [3:0]  mul_a_reg_o,
	output reg  [3:0]  mul_b_reg_o,
	output reg         x_pf_en_o,
	output reg  [3:0]  x_pf_reg_o,
	output reg  [3:0]  x_pf_mod_o,
	output reg         x_pf_w12_o,
	output reg  [3:0]  x_pf_dst_o,
	output reg         y_pf_en_o,
	output reg  [3:0]  y_pf_reg_o,
	output reg  [3:0]  y_pf_mod_o,
	output reg         y_pf_w12_o,
	output reg  [3:0]  y_pf_dst_o,
	output reg         awb_en_o,
	output reg         awb_indirect_o,
	output reg  [3:0]  awb_reg_o,
	output reg  [3:0]  awb_inc_o,
	output reg  [8:0]  flags_o
);

// ----------------------------------------
// states and storage
// ----------------------------------------
localparam [2:0] S_RUN   = 3'h1;
localparam [2:0] S_WORD2 = 3'h2;
localparam [2:0] S_STALL = 3'h4;

reg  [2:0]  state_reg;
reg  [1:0]  stall_reg;
reg  [23:0] first_reg;
reg         skip_pend_reg;
reg         drop2_reg;
reg         ctrl_en_reg;
reg  [3:0]  err_reg;
reg  [3:0]  err_next;
reg  [8:0]  flags_next;
reg  [31:0] count_reg;

// ----------------------------------------
// functions
// ----------------------------------------
// prefetch base register: seven modes on r0, seven on r1, r1+w12, none
function [3:0] pf_reg;
	input [3:0] sel;
	input [3:0] r0;
	input [3:0] r1;
	begin
		pf_reg = (sel < `DIO_PF_HALF) ? r0 : r1;
	end
endfunction

// post-modify amount as a signed nibble: +6 +4 +2 0 -6 -4 -2
function [3:0] pf_mod;
	input [3:0] sel;
	reg   [3:0] idx;
	begin
		idx = (sel < `DIO_PF_HALF) ? sel : sel - `DIO_PF_HALF;
		case (idx)
		4'h0: pf_mod = 4'h6;
		4'h1: pf_mod = 4'h4;
		4'h2: pf_mod = 4'h2;
		4'h4: pf_mod = 4'ha;
		4'h5: pf_mod = 4'hc;
		4'h6: pf_mod = 4'he;
		default: pf_mod = 4'h0;
		endcase
		if (sel >= `DIO_PF_W12)
			pf_mod = 4'h0;
	end
endfunction

// branch condition against the held flags
function cond_true;
	input [3:0] c;
	input [8:0] f;
	reg         ge;
	begin
		ge = (f[`DIO_FL_N] == f[`DIO_FL_OV]);
		case (c)
		4'h0: cond_true = f[`DIO_FL_OV];
		4'h1: cond_true = f[`DIO_FL_C];
		4'h2: cond_true = f[`DIO_FL_Z];
		4'h3: cond_true = f[`DIO_FL_N];
		4'h4: cond_true = ge & ~f[`DIO_FL_Z];
		4'h5: cond_true = ge;
		4'h6: cond_true = f[`DIO_FL_C] & ~f[`DIO_FL_Z];
		4'h7: cond_true = 1'b1;
		4'h8: cond_true = ~f[`DIO_FL_OV];
		4'h9: cond_true = ~f[`DIO_FL_C];
		4'ha: cond_true = ~f[`DIO_FL_Z];
		4'hb: cond_true = ~f[`DIO_FL_N];
		4'hc: cond_true = f[`DIO_FL_OA];
		4'hd: cond_true = f[`DIO_FL_OB];
		4'he: cond_true = f[`DIO_FL_SA];
		default: cond_true = f[`DIO_FL_SB];
		endcase
	end
endfunction

// ----------------------------------------
// decode of the offered word
// ----------------------------------------
wire [23:0] w    = fetch_word_i;
wire [7:0]  opc  = w[`DIO_F_OPC];
wire        fire = fetch_valid_i & fetch_ready_o;
wire        is_two = (opc == `DIO_OP_CALL2) | (opc == `DIO_OP_GOTO2) |
	(opc == `DIO_OP_DO2);
wire        is_br  = (opc[7:4] == `DIO_BR_NIB);
wire        is_mac = (w[`DIO_F_MAC] == `DIO_MAC_TAG);
wire        br_hit = is_br & cond_true(opc[3:0], flags_o);
wire        is_ret = (opc == `DIO_OP_RET) | (opc == `DIO_OP_RETI);
wire        is_one_x = (opc == `DIO_OP_IND) | (opc == `DIO_OP_TBL) |
	(opc == `DIO_OP_MOVD) | br_hit;
wire [1:0]  extra = is_ret ? `DIO_XTRA_TWO :
	(is_one_x ? `DIO_XTRA_ONE : 2'h0);
wire        run_new = state_reg[0] & fire & ~skip_pend_reg & ~is_two;
wire        w2_new  = state_reg[1] & fire & ~drop2_reg;
wire        wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

// ----------------------------------------
// sticky errors and flags
// ----------------------------------------
always @* begin
	err_next = err_reg;
	if (wr && wb_adr_i == `DIO_A_ERR && wb_sel_i[0])
		err_next = err_next & ~wb_dat_i[3:0];
	// a fresh error wins over a clear in the same cycle
	if (w2_new && w[`DIO_F_HI8] != 8'h00)
		err_next[`DIO_E_WORD2] = 1'b1;
	if (w2_new && first_reg[0])
		err_next[`DIO_E_ODD] = 1'b1;
	if (run_new && opc == `DIO_OP_LIT && w[`DIO_B_BYTE] &&
			w[`DIO_F_LIT] > `DIO_BYTE_MAX)
		err_next[`DIO_E_LIT] = 1'b1;
	if (run_new && is_mac && !w[`DIO_B_SQR] && w[`DIO_F_PAIR] > `DIO_PAIR_MAX)
		err_next[`DIO_E_PAIR] = 1'b1;
end

always @* begin
	flags_next = flags_o;
	if (wr && wb_adr_i == `DIO_A_STAT) begin
		if (wb_sel_i[0])
			flags_next[7:0] = wb_dat_i[7:0];
		if (wb_sel_i[1])
			flags_next[8] = wb_dat_i[8];
	end
	// datapath results override a software write in the same cycle
	flags_next = (flags_next & ~flag_we_i) | (flag_val_i & flag_we_i);
end

// ----------------------------------------
// wishbone slave
// ----------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		wb_ack_o    <= 1'b0;
		wb_dat_o    <= 32'h0;
		ctrl_en_reg <= `DIO_RST_CTRL;
		err_reg     <= 4'h0;
		flags_o     <= 9'h0;
		count_reg   <= 32'h0;
	end else begin
		wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
		err_reg  <= err_next;
		flags_o  <= flags_next;
		if (exec_valid_o)
			count_reg <= count_reg + 32'h1;
		if (wr && wb_adr_i == `DIO_A_CTRL && wb_sel_i[0])
			ctrl_en_reg <= wb_dat_i[0];
		case (wb_adr_i)
		`DIO_A_CTRL: wb_dat_o <= {31'h0, ctrl_en_reg};
		`DIO_A_STAT: wb_dat_o <= {23'h0, flags_o};
		`DIO_A_ERR:  wb_dat_o <= {28'h0, err_reg};
		`DIO_A_CNT:  wb_dat_o <= count_reg;
		default:     wb_dat_o <= 32'h0;
		endcase
	end
end

// ----------------------------------------
// sequencer
// ----------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		state_reg       <= S_RUN;
		stall_reg       <= 2'h0;
		first_reg       <= 24'h0;
		skip_pend_reg   <= 1'b0;
		drop2_reg       <= 1'b0;
		fetch_ready_o   <= 1'b0;
		exec_valid_o    <= 1'b0;
		exec_nop_o      <= 1'b0;
		exec_taken_o    <= 1'b0;
		exec_two_word_o <= 1'b0;
		exec_opcode_o   <= 8'h0;
		operand_ext_o   <= 24'h0;
		program_addr_imm_o <= 23'h0;
	end else begin
		exec_valid_o  <= 1'b0;
		exec_nop_o    <= 1'b0;
		exec_taken_o  <= 1'b0;
		fetch_ready_o <= ctrl_en_reg;
		case (state_reg)
		S_RUN: begin
			if (fire) begin
				exec_opcode_o   <= opc;
				exec_two_word_o <= 1'b0;
				first_reg       <= w;
				if (skip_pend_reg) begin
					// the discarded word is the skip's extra cycle
					skip_pend_reg <= 1'b0;
					drop2_reg     <= is_two;
					exec_nop_o    <= 1'b1;
					if (is_two)
						state_reg <= S_WORD2;
				end else if (is_two) begin
					drop2_reg <= 1'b0;
					state_reg <= S_WORD2;
				end else begin
					exec_valid_o <= (opc != `DIO_OP_NOP);
					exec_nop_o   <= (opc == `DIO_OP_NOP);
					exec_taken_o <= br_hit | is_ret | (opc == `DIO_OP_IND);
					if (opc == `DIO_OP_SKIP && skip_true_i)
						skip_pend_reg <= 1'b1;
					if (extra != 2'h0) begin
						stall_reg     <= extra;
						state_reg     <= S_STALL;
						fetch_ready_o <= 1'b0;
					end
				end
			end
		end
		S_WORD2: begin
			if (fire) begin
				state_reg <= S_RUN;
				if (drop2_reg) begin
					exec_nop_o <= 1'b1;
				end else begin
					exec_valid_o    <= 1'b1;
					exec_two_word_o <= 1'b1;
					exec_taken_o    <= (first_reg[`DIO_F_OPC] != `DIO_OP_DO2);
					operand_ext_o   <= w;
					program_addr_imm_o <= {w[`DIO_F_ADRH],
						first_reg[`DIO_F_ADRL]};
				end
			end
		end
		S_STALL: begin
			// the pc-change cycles run as no-operations
			exec_nop_o <= 1'b1;
			stall_reg  <= stall_reg - 2'h1;
			if (stall_reg == `DIO_XTRA_ONE)
				state_reg <= S_RUN;
			else
				fetch_ready_o <= 1'b0;
		end
		default: begin
			state_reg <= S_RUN;
		end
		endcase
	end
end

// ----------------------------------------
// operand fields, held from each unskipped single word, no-operation words included
// ----------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		base_reg_o <= 4'h0;
		src_reg_o  <= 4'h0;
		dst_reg_o  <= 4'h0;
		implicit_work_register_o <= `DIO_W0;
		bit_position_field_o <= 4'h0;
		unsigned_imm_ten_o   <= 10'h0;
		byte_mode_o      <= 1'b0;
		signed_imm_ten_o <= 16'h0;
		acc_sel_o   <= 1'b0;
		mul_a_reg_o <= `DIO_W4;
		mul_b_reg_o <= `DIO_W4;
		x_pf_en_o   <= 1'b0;
		x_pf_reg_o  <= `DIO_W8;
		x_pf_mod_o  <= 4'h0;
		x_pf_w12_o  <= 1'b0;
		x_pf_dst_o  <= `DIO_W4;
		y_pf_en_o   <= 1'b0;
		y_pf_reg_o  <= `DIO_W10;
		y_pf_mod_o  <= 4'h0;
		y_pf_w12_o  <= 1'b0;
		y_pf_dst_o  <= `DIO_W4;
		awb_en_o    <= 1'b0;
		awb_indirect_o <= 1'b0;
		awb_reg_o   <= `DIO_W13;
		awb_inc_o   <= 4'h0;
	end else if (run_new) begin
		base_reg_o <= w[`DIO_F_BASE];
		src_reg_o  <= w[`DIO_F_SRC];
		dst_reg_o  <= w[`DIO_F_DST];
		implicit_work_register_o <= `DIO_W0;
		bit_position_field_o <= w[`DIO_F_BIT_POSITION_FIELD];
		byte_mode_o <= w[`DIO_B_BYTE];
		// byte mode keeps only the low eight literal bits
		unsigned_imm_ten_o <= w[`DIO_B_BYTE] ?
			(w[`DIO_F_LIT] & `DIO_BYTE_MAX) : w[`DIO_F_LIT];
		signed_imm_ten_o <= {{6{w[`DIO_B_LSIGN]}}, w[`DIO_F_LIT]};
		if (is_mac) begin
			acc_sel_o <= w[`DIO_B_ACC];
			if (w[`DIO_B_SQR]) begin
				mul_a_reg_o <= `DIO_W4 + {2'h0, w[`DIO_F_SQP]};
				mul_b_reg_o <= `DIO_W4 + {2'h0, w[`DIO_F_SQP]};
			end else begin
				// pairs 4-5 4-6 4-7 5-6 5-7 6-7; unused codes fall to 6-7
				case (w[`DIO_F_PAIR])
				3'h0: {mul_a_reg_o, mul_b_reg_o} <= 8'h45;
				3'h1: {mul_a_reg_o, mul_b_reg_o} <= 8'h46;
				3'h2: {mul_a_reg_o, mul_b_reg_o} <= 8'h47;
				3'h3: {mul_a_reg_o, mul_b_reg_o} <= 8'h56;
				3'h4: {mul_a_reg_o, mul_b_reg_o} <= 8'h57;
				default: {mul_a_reg_o, mul_b_reg_o} <= 8'h67;
				endcase
			end
			x_pf_en_o  <= (w[`DIO_F_WX] != `DIO_PF_NONE);
			x_pf_reg_o <= pf_reg(w[`DIO_F_WX], `DIO_W8, `DIO_W9);
			x_pf_mod_o <= pf_mod(w[`DIO_F_WX]);
			x_pf_w12_o <= (w[`DIO_F_WX] == `DIO_PF_W12);
			x_pf_dst_o <= `DIO_W4 + {2'h0, w[`DIO_F_XD]};
			y_pf_en_o  <= (w[`DIO_F_WY] != `DIO_PF_NONE);
			y_pf_reg_o <= pf_reg(w[`DIO_F_WY], `DIO_W10, `DIO_W11);
			y_pf_mod_o <= pf_mod(w[`DIO_F_WY]);
			y_pf_w12_o <= (w[`DIO_F_WY] == `DIO_PF_W12);
			y_pf_dst_o <= `DIO_W4 + {2'h0, w[`DIO_F_YD]};
			// code 1 direct, code 2 indirect with post-increment, else none
			awb_en_o       <= (w[`DIO_F_AWB] == 2'h1) | (w[`DIO_F_AWB] == 2'h2);
			awb_indirect_o <= (w[`DIO_F_AWB] == 2'h2);
			awb_reg_o      <= `DIO_W13;
			awb_inc_o      <= (w[`DIO_F_AWB] == 2'h2) ? `DIO_AWB_INC : 4'h0;
		end
	end
end

endmodule
`default_nettype wire

// ---- tb/dio_decoder_assertions.sv ----
// Purpose: concurrent checks on the ports of the decode block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every instance of the decoder
`timescale 1ns/10ps
`default_nettype none
module dio_decoder_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        fetch_valid_i,
	input wire logic [23:0] fetch_word_i,
	input wire logic        fetch_ready_o,
	input wire logic        skip_true_i,
	input wire logic        exec_valid_o,
	input wire logic        exec_nop_o,
	input wire logic        exec_taken_o,
	input wire logic        exec_two_word_o,
	input wire logic [3:0]  implicit_work_register_o,
	input wire logic [9:0]  unsigned_imm_ten_o,
	input wire logic        byte_mode_o,
	input wire logic [15:0] signed_imm_ten_o,
	input wire logic [3:0]  mul_a_reg_o,
	input wire logic [3:0]  mul_b_reg_o,
	input wire logic        x_pf_en_o,
	input wire logic [3:0]  x_pf_dst_o,
	input wire logic        awb_en_o,
	input wire logic [3:0]  awb_reg_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// helper state
	// ----------------------------------------
	// skipped words and second words are kept out of the timing checks
	logic skip_d;
	logic first_d;
	wire logic       take = fetch_valid_i && fetch_ready_o;
	wire logic [7:0] op   = fetch_word_i[23:16];
	wire logic       live = take && !skip_d && !first_d;
	always @(posedge clk_i) begin
		skip_d  <= take && op == 8'ha6 && skip_true_i;
		first_d <= take && (op == 8'h02 || op == 8'h04 || op == 8'h08);
	end
	sequence s_first;
		live && (op == 8'h02 || op == 8'h04 || op == 8'h08);
	endsequence
	sequence s_mac;
		live && fetch_word_i[23:19] == 5'h18;
	endsequence
	sequence s_stall;
		exec_valid_o && !fetch_ready_o ##1 exec_nop_o;
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_two_word: assert property (s_first ##1 take |=> exec_valid_o && exec_two_word_o)
		else $error("two-word timing");
	chk_lone_second: assert property (live && op == 8'h00 |=> exec_nop_o && !exec_valid_o)
		else $error("lone second word");
	chk_branch_stall: assert property (live && op == 8'h37 |=> (exec_taken_o and s_stall))
		else $error("branch stall");
	chk_two_cycle: assert property (live && op inside {8'h01, 8'hba, 8'hbe} |=> s_stall)
		else $error("two-cycle class");
	chk_return_len: assert property (live && op inside {8'h06, 8'h07} |=> exec_valid_o ##1 exec_nop_o [*2])
		else $error("return length");
	chk_mul_pair: assert property (s_mac |=> mul_a_reg_o >= 4'h4 && mul_b_reg_o <= 4'h7 && mul_a_reg_o <= mul_b_reg_o)
		else $error("multiply pair");
	chk_work_reg: assert property (implicit_work_register_o == 4'h0)
		else $error("implicit register");
	chk_awb_reg: assert property (awb_en_o |-> awb_reg_o == 4'hd)
		else $error("write-back register");
	chk_pf_dest: assert property (x_pf_en_o |-> x_pf_dst_o inside {[4'h4:4'h7]})
		else $error("prefetch destination");
	chk_byte_lit: assert property (byte_mode_o |-> unsigned_imm_ten_o <= 10'h0ff)
		else $error("byte literal range");
	chk_sign_ext: assert property (signed_imm_ten_o[15:9] == {7{signed_imm_ten_o[9]}})
		else $error("sign extension");
endmodule
bind dio_decoder dio_decoder_chk dio_decoder_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.fetch_valid_i(fetch_valid_i), .fetch_word_i(fetch_word_i),
	.fetch_ready_o(fetch_ready_o), .skip_true_i(skip_true_i),
	.exec_valid_o(exec_valid_o), .exec_nop_o(exec_nop_o), .exec_taken_o(exec_taken_o),
	.exec_two_word_o(exec_two_word_o), .implicit_work_register_o(implicit_work_register_o),
	.unsigned_imm_ten_o(unsigned_imm_ten_o), .byte_mode_o(byte_mode_o),
	.signed_imm_ten_o(signed_imm_ten_o), .mul_a_reg_o(mul_a_reg_o),
	.mul_b_reg_o(mul_b_reg_o), .x_pf_en_o(x_pf_en_o), .x_pf_dst_o(x_pf_dst_o),
	.awb_en_o(awb_en_o), .awb_reg_o(awb_reg_o));
`default_nettype wire

// ---- tb/dio_decoder_test.sv ----
// Purpose: self-checking bench for the instruction decode block
// Assumes: 200 MHz clock, synchronous active-high reset
// Notes:   cycle costs are counted from the execute pulses
`timescale 1ns/10ps
`default_nettype none
module dio_decoder_test;
	logic        clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic        fetch_valid_i = 1'b0, skip_true_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0]  wb_sel_i = 4'hf;
	logic [23:0] fetch_word_i = 24'h0;
	logic [8:0]  flag_we_i = 9'h0, flag_val_i = 9'h0, flags_o;
	logic [31:0] wb_dat_o;
	logic [23:0] operand_ext_o;
	logic [22:0] program_addr_imm_o;
	logic [15:0] signed_imm_ten_o;
	logic [9:0]  unsigned_imm_ten_o;
	logic [7:0]  exec_opcode_o;
	logic [3:0]  base_reg_o, src_reg_o, dst_reg_o, implicit_work_register_o, bit_position_field_o;
	logic [3:0]  mul_a_reg_o, mul_b_reg_o, x_pf_reg_o, x_pf_mod_o, x_pf_dst_o, y_pf_reg_o;
	logic [3:0]  y_pf_mod_o, y_pf_dst_o, awb_reg_o, awb_inc_o;
	logic        wb_ack_o, fetch_ready_o, exec_valid_o, exec_nop_o, exec_taken_o, exec_two_word_o;
	logic        byte_mode_o, acc_sel_o, x_pf_en_o, x_pf_w12_o, y_pf_en_o, y_pf_w12_o;
	logic        awb_en_o, awb_indirect_o;
	int          n_fail = 0, checked = 0, cv = 0, cn = 0, ct = 0, bv, bn, bt;
	dio_decoder dio_decoder_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.fetch_valid_i(fetch_valid_i), .fetch_word_i(fetch_word_i), .fetch_ready_o(fetch_ready_o),
		.skip_true_i(skip_true_i), .flag_we_i(flag_we_i), .flag_val_i(flag_val_i),
		.exec_valid_o(exec_valid_o), .exec_nop_o(exec_nop_o), .exec_taken_o(exec_taken_o),
		.exec_two_word_o(exec_two_word_o), .exec_opcode_o(exec_opcode_o),
		.operand_ext_o(operand_ext_o), .program_addr_imm_o(program_addr_imm_o),
		.base_reg_o(base_reg_o), .src_reg_o(src_reg_o), .dst_reg_o(dst_reg_o),
		.implicit_work_register_o(implicit_work_register_o),
		.bit_position_field_o(bit_position_field_o), .unsigned_imm_ten_o(unsigned_imm_ten_o),
		.byte_mode_o(byte_mode_o), .signed_imm_ten_o(signed_imm_ten_o), .acc_sel_o(acc_sel_o),
		.mul_a_reg_o(mul_a_reg_o), .mul_b_reg_o(mul_b_reg_o), .x_pf_en_o(x_pf_en_o),
		.x_pf_reg_o(x_pf_reg_o), .x_pf_mod_o(x_pf_mod_o), .x_pf_w12_o(x_pf_w12_o),
		.x_pf_dst_o(x_pf_dst_o), .y_pf_en_o(y_pf_en_o), .y_pf_reg_o(y_pf_reg_o),
		.y_pf_mod_o(y_pf_mod_o), .y_pf_w12_o(y_pf_w12_o), .y_pf_dst_o(y_pf_dst_o),
		.awb_en_o(awb_en_o), .awb_indirect_o(awb_indirect_o), .awb_reg_o(awb_reg_o),
		.awb_inc_o(awb_inc_o), .flags_o(flags_o));
	always #2.5 clk_i = ~clk_i;
	// execute pulses are tallied so cycle costs need no fixed latency
	always @(posedge clk_i) begin
		cv <= cv + 32'(exec_valid_o);
		cn <= cn + 32'(exec_nop_o);
		ct <= ct + 32'(exec_taken_o);
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
		do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) begin
			n_fail++;
			$display("wrong value at %0t: no bus acknowledge", $time);
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	// valid stays up between words so back-to-back fetches need no gap
	task automatic issue(input logic [23:0] w);
		int n;
		n = 0;
		fetch_word_i <= w; fetch_valid_i <= 1'b1;
		do begin @(negedge clk_i); n++; end while (fetch_ready_o !== 1'b1 && n < 50);
		if (fetch_ready_o !== 1'b1) begin
			n_fail++;
			$display("wrong value at %0t: fetch never accepted", $time);
		end
		@(posedge clk_i);
	endtask
	task automatic idle(input int k);
		fetch_valid_i <= 1'b0;
		repeat (k) @(posedge clk_i);
	endtask
	task automatic mark;
		bv = cv; bn = cn; bt = ct;
	endtask
	task automatic delta(input int dv, input int dn, input int dt);
		chk(cv - bv, dv);
		chk(cn - bn, dn);
		if (dt >= 0) chk(ct - bt, dt);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		rd(8'h00, 32'h1);
		wr(8'h0c, 32'hffff);
		rd(8'h0c, 32'h0);
		rd(8'h20, 32'h0);
	endtask
	task automatic t_flags;
		flag_we_i <= 9'h1ff; flag_val_i <= 9'h1a5;
		@(posedge clk_i);
		flag_we_i <= 9'h0;
		@(negedge clk_i);
		chk(32'(flags_o), 32'h1a5);
		@(posedge clk_i);
		rd(8'h04, 32'h1a5);
		wr(8'h04, 32'h0);
		rd(8'h04, 32'h0);
	endtask
	task automatic t_cycles;
		mark;
		issue(24'h370000);
		issue(24'h300000);
		idle(4);
		delta(2, 1, 1);
		mark;
		issue(24'h060000);
		issue(24'hba0000);
		issue(24'hbe0000);
		issue(24'h010000);
		idle(5);
		delta(4, 5, 2);
	endtask
	task automatic t_two;
		mark;
		issue(24'h021234);
		issue(24'h000045);
		idle(3);
		delta(1, 0, 1);
		chk(32'(program_addr_imm_o), 32'h451234);
		chk(32'(operand_ext_o), 32'h45);
		chk(32'(exec_two_word_o), 32'h1);
		issue(24'h040001);
		issue(24'h000000);
		idle(2);
		mark;
		issue(24'h00abcd);
		idle(3);
		delta(0, 1, 0);
		issue(24'h080000);
		issue(24'h120000);
		idle(3);
	endtask
	task automatic t_skip;
		mark;
		skip_true_i <= 1'b1;
		issue(24'ha60000);
		skip_true_i <= 1'b0;
		issue(24'h020010);
		issue(24'h000000);
		skip_true_i <= 1'b1;
		issue(24'ha60000);
		skip_true_i <= 1'b0;
		issue(24'hb00000);
		idle(4);
		delta(2, 3, -1);
	endtask
	task automatic t_ops;
		issue(24'hb0f2c5);
		idle(3);
		chk({bit_position_field_o, base_reg_o, src_reg_o, dst_reg_o, 16'h0}, 32'hfe550000);
		chk({byte_mode_o, unsigned_imm_ten_o, implicit_work_register_o, 17'h0}, 32'h85800000);
		chk(32'(signed_imm_ten_o), 32'hff2c);
		issue(24'hc2fe0e);
		idle(3);
		chk({mul_a_reg_o, mul_b_reg_o, x_pf_reg_o, x_pf_dst_o, y_pf_reg_o, y_pf_dst_o,
			awb_reg_o, awb_inc_o}, 32'h6797a4d2);
		chk(32'({acc_sel_o, x_pf_en_o, x_pf_w12_o, y_pf_en_o, y_pf_w12_o, awb_en_o,
			awb_indirect_o}), 32'h7b);
		issue(24'hc50f3c);
		idle(3);
		chk(32'({mul_a_reg_o, mul_b_reg_o, x_pf_en_o, y_pf_en_o, awb_en_o}), 32'h330);
		// pair 4-5, w8 post +6 into w5, w11 post -6 into w6, direct write-back
		issue(24'hc010ad);
		idle(3);
		chk({mul_a_reg_o, mul_b_reg_o, x_pf_reg_o, x_pf_mod_o, x_pf_dst_o, y_pf_reg_o,
			y_pf_mod_o, y_pf_dst_o}, 32'h45865ba6);
		chk(32'({exec_opcode_o, awb_en_o, awb_indirect_o, awb_inc_o}), 32'h3020);
		rd(8'h08, 32'h7);
		wr(8'h08, 32'hf);
		rd(8'h08, 32'h0);
		// fifteen instructions executed in all, skipped and no-operation words excluded
		rd(8'h0c, 32'hf);
	endtask
	// ----------------------------------------
	// run
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs;
		t_flags;
		t_cycles;
		t_two;
		t_skip;
		t_ops;
		final_report;
	end
	initial begin
		repeat (4000) @(posedge clk_i);
		n_fail++;
		$display("wrong value at %0t: watchdog expired", $time);
		final_report;
	end
endmodule
`default_nettype wire
